/* File: src/uer_pkg.sv */
package uer_pkg;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [2:0] OFS_SHARED0   = 3'h0;
    localparam logic [2:0] OFS_SHARED1   = 3'h1;
    localparam logic [2:0] OFS_STOP2     = 3'h7;

    // ****************************************
    // Access conditions
    // ****************************************
    localparam logic [7:0] LCR_ENHANCED  = 8'hbf;
    localparam int         LCR_DLAB_BIT  = 7;
    localparam logic [7:0] DIV_ZERO      = 8'h00;

    // ****************************************
    // Field positions, reset values and transmit trigger limit
    // ****************************************
    localparam int         TRG_SEL_BIT   = 7;
    localparam int         FCNT_SEL_BIT  = 7;
    localparam int         FEATURE_CONTROL_TBL_LO   = 4;
    localparam int         FEATURE_CONTROL_TBL_HI   = 5;
    localparam logic [7:0] FEATURE_CONTROL_RESET    = 8'h20;
    localparam logic [7:0] STOP2_RESET   = 8'h00;
    localparam logic [6:0] TRG_RESET     = 7'h00;
    localparam logic [6:0] TX_TRG_MAX    = 7'h40;

endpackage : uer_pkg

/* File: src/uer_sel_if.sv */
`timescale 1ns/1ps
interface uer_sel_if;
    logic enh_sel;
    logic id_sel;

    modport dec (output enh_sel, output id_sel);
    modport use_sel (input enh_sel, input id_sel);
endinterface : uer_sel_if

/* File: src/uer_access_dec.sv */
`timescale 1ns/1ps
// ****************************************
// Bank-select decode from line control and divisor
// ****************************************
module uer_access_dec (
    input  wire logic [7:0] line_control_reg,
    input  wire logic [7:0] divisor_low_byte,
    input  wire logic [7:0] divisor_high_byte,
    uer_sel_if.dec          sel
);
    always_comb begin
        sel.enh_sel = (line_control_reg == uer_pkg::LCR_ENHANCED);
        sel.id_sel  = line_control_reg[uer_pkg::LCR_DLAB_BIT]
                      && (line_control_reg != uer_pkg::LCR_ENHANCED)
                      && (divisor_low_byte == uer_pkg::DIV_ZERO)
                      && (divisor_high_byte == uer_pkg::DIV_ZERO);  // [R2] [R3]
    end
endmodule : uer_access_dec

/* File: src/uer_regs.sv */
`timescale 1ns/1ps
// Behaviour
// (R1) Offset 7 stop char, enhanced bank, resets zero
// (R2) Revision at offset 0 under id condition
// (R3) Fixed identification at offset 1, read-only
// (R4) Enhanced write offset 0 hits trigger register
// (R5) Bit7 one loads transmit trigger, 0..0x40
// (R6) Bit7 zero loads receive trigger level
// (R7) Enhanced read offset 0 returns level counter
// (R8) Bit7 selects receive or transmit count
// (R9) Each counter read alternates reported FIFO
// (R10) Feature control offset 1, table bits 5:4
// (R11) Feature control bits 7:6 reserved read-only
// (R12) First counter read after reset reports receive
module uer_regs #(
    parameter logic [7:0] REVISION_CODE  = 8'h01, // Arbitrary value
    parameter logic [7:0] DEVICE_ID_CODE = 8'h5a  // Arbitrary value
) (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic [2:0] reg_addr,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    input  wire logic [7:0] reg_wdata,
    input  wire logic [7:0] line_control_reg,
    input  wire logic [7:0] divisor_low_byte,
    input  wire logic [7:0] divisor_high_byte,
    input  wire logic [6:0] rx_fifo_count,
    input  wire logic [6:0] tx_fifo_count,
    output logic      [7:0] reg_rdata,
    output logic            reg_rvalid,
    output logic      [7:0] second_stop_char,
    output logic      [6:0] receive_trigger_value,
    output logic      [6:0] transmit_trigger_value,
    output logic      [1:0] trigger_table_sel
);
    // ****************************************
    // Bank decode
    // ****************************************
    uer_sel_if sel_bus ();

    uer_access_dec u_dec (
        .line_control_reg  (line_control_reg),
        .divisor_low_byte  (divisor_low_byte),
        .divisor_high_byte (divisor_high_byte),
        .sel               (sel_bus.dec)
    );

    // ****************************************
    // Register state
    // ****************************************
    logic [7:0] stop2_r,   stop2_nxt;
    logic [6:0] rx_trg_r,  rx_trg_nxt;
    logic [6:0] tx_trg_r,  tx_trg_nxt;
    logic [1:0] table_r,   table_nxt;
    logic       fc_tx_r,   fc_tx_nxt;
    logic [7:0] rdata_r,   rdata_nxt;
    logic       rvalid_r,  rvalid_nxt;

    logic       enh;
    logic       idc;
    logic       hit_shared0;
    logic [7:0] rd_mux;

    assign enh         = sel_bus.enh_sel;
    assign idc         = sel_bus.id_sel;
    assign hit_shared0 = (reg_addr == uer_pkg::OFS_SHARED0);

    // ****************************************
    // Configuration writes
    // ****************************************
    always_comb begin
        stop2_nxt  = stop2_r;
        rx_trg_nxt = rx_trg_r;
        tx_trg_nxt = tx_trg_r;
        table_nxt  = table_r;
        if (reg_wr && enh) begin
            case (reg_addr)
                uer_pkg::OFS_STOP2: begin
                    stop2_nxt = reg_wdata;  // [R1]
                end
                uer_pkg::OFS_SHARED0: begin
                    if (reg_wdata[uer_pkg::TRG_SEL_BIT]) begin  // [R4]
                        // Out-of-range transmit levels clamp to TX_TRG_MAX so the trigger never exceeds the FIFO
                        if (reg_wdata[6:0] > uer_pkg::TX_TRG_MAX) begin
                            tx_trg_nxt = uer_pkg::TX_TRG_MAX;  // [R5]
                        end else begin
                            tx_trg_nxt = reg_wdata[6:0];  // [R5]
                        end
                    end else begin
                        rx_trg_nxt = reg_wdata[6:0];  // [R6]
                    end
                end
                uer_pkg::OFS_SHARED1: begin
                    // Reserved bits 7:6 are not stored
                    table_nxt = reg_wdata[uer_pkg::FEATURE_CONTROL_TBL_HI:uer_pkg::FEATURE_CONTROL_TBL_LO]; // [R10] [R11]
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            stop2_r  <= uer_pkg::STOP2_RESET;  // [R1]
            rx_trg_r <= uer_pkg::TRG_RESET;
            tx_trg_r <= uer_pkg::TRG_RESET;
            table_r  <= uer_pkg::FEATURE_CONTROL_RESET[uer_pkg::FEATURE_CONTROL_TBL_HI:uer_pkg::FEATURE_CONTROL_TBL_LO]; // [R10]
        end else begin
            stop2_r  <= stop2_nxt;
            rx_trg_r <= rx_trg_nxt;
            tx_trg_r <= tx_trg_nxt;
            table_r  <= table_nxt;
        end
    end

    // ****************************************
    // Read data selection
    // ****************************************
    // Identification writes are simply dropped [R3]
    always_comb begin
        rd_mux = 8'h00;
        if (enh) begin
            case (reg_addr)
                uer_pkg::OFS_STOP2: begin
                    rd_mux = stop2_r;  // [R1]
                end
                uer_pkg::OFS_SHARED0: begin
                    if (fc_tx_r) begin
                        rd_mux = {1'b1, tx_fifo_count};  // [R7] [R8]
                    end else begin
                        rd_mux = {1'b0, rx_fifo_count};  // [R7] [R8]
                    end
                end
                uer_pkg::OFS_SHARED1: begin
                    rd_mux = uer_pkg::FEATURE_CONTROL_RESET & 8'hcf;  // [R11]
                    rd_mux[uer_pkg::FEATURE_CONTROL_TBL_HI:uer_pkg::FEATURE_CONTROL_TBL_LO] = table_r; // [R10]
                end
                default: begin
                end
            endcase
        end else if (idc) begin
            case (reg_addr)
                uer_pkg::OFS_SHARED0: rd_mux = REVISION_CODE;   // [R2]
                uer_pkg::OFS_SHARED1: rd_mux = DEVICE_ID_CODE;  // [R3]
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Read path and counter alternation
    // ****************************************
    always_comb begin
        fc_tx_nxt  = fc_tx_r;
        rdata_nxt  = rdata_r;
        rvalid_nxt = reg_rd;
        if (reg_rd) begin
            rdata_nxt = rd_mux;
            // Only a counter read flips the selection, other reads leave it
            if (enh && hit_shared0) begin
                fc_tx_nxt = ~fc_tx_r;  // [R9]
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!reset_n) begin
            fc_tx_r  <= 1'b0;  // [R12]
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            fc_tx_r  <= fc_tx_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign reg_rdata              = rdata_r;
    assign reg_rvalid             = rvalid_r;
    assign second_stop_char       = stop2_r;
    assign receive_trigger_value  = rx_trg_r;
    assign transmit_trigger_value = tx_trg_r;
    assign trigger_table_sel      = table_r;

endmodule : uer_regs

/* File: tb/uer_regs_properties.sv */
`timescale 1ns/1ps
// *****
// Register bank properties
// *****
module uer_regs_properties #(
    parameter logic [7:0] REVISION_CODE  = 8'h01,
    parameter logic [7:0] DEVICE_ID_CODE = 8'h5a
) (
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic [2:0] reg_addr,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic [7:0] line_control_reg,
    input wire logic [7:0] divisor_low_byte,
    input wire logic [7:0] divisor_high_byte,
    input wire logic [6:0] rx_fifo_count,
    input wire logic [6:0] tx_fifo_count,
    input wire logic [7:0] reg_rdata,
    input wire logic       reg_rvalid,
    input wire logic [7:0] second_stop_char,
    input wire logic [6:0] receive_trigger_value,
    input wire logic [6:0] transmit_trigger_value,
    input wire logic [1:0] trigger_table_sel
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    logic       enh, idm, crd, w0, sel_r, sel_nxt;
    logic [7:0] cnt_exp;
    assign enh = line_control_reg == uer_pkg::LCR_ENHANCED;
    assign idm = line_control_reg[7] && !enh && {divisor_low_byte, divisor_high_byte} == 16'h0000;
    assign crd = reg_rd && reg_addr == 3'h0 && enh;
    assign w0  = reg_wr && reg_addr == 3'h0 && enh;
    // Model of which FIFO the next counter read reports
    always_comb sel_nxt = reset_n && (crd ^ sel_r);
    always_ff @(posedge clk_sys) sel_r <= sel_nxt;
    assign cnt_exp = {sel_r, sel_r ? tx_fifo_count : rx_fifo_count};
    sequence cnt_rd_s;
        crd ##1 reg_rvalid;
    endsequence
    AST_CNT: assert property (crd |-> cnt_rd_s ##0 reg_rdata == $past(cnt_exp))
        else $error("level count");
    AST_STOP: assert property (reg_wr && reg_addr == 3'h7 && enh |=> second_stop_char == $past(reg_wdata))
        else $error("stop char");
    AST_TX: assert property (w0 && reg_wdata[7] && reg_wdata[6:0] <= 7'h40 |=> transmit_trigger_value == $past(reg_wdata[6:0]))
        else $error("tx trigger");
    AST_RX: assert property (w0 && !reg_wdata[7] |=> receive_trigger_value == $past(reg_wdata[6:0]))
        else $error("rx trigger");
    AST_LOCK: assert property (reg_wr && !enh |=> $stable(second_stop_char) && $stable(transmit_trigger_value))
        else $error("write outside bank");
    AST_REV: assert property (reg_rd && reg_addr == 3'h0 && idm |=> reg_rdata == REVISION_CODE)
        else $error("revision");
    AST_ID: assert property (reg_rd && reg_addr == 3'h1 && idm |=> reg_rdata == DEVICE_ID_CODE)
        else $error("ident");
    AST_FEATURE_CONTROL: assert property (reg_rd && !reg_wr && reg_addr == 3'h1 && enh |=> reg_rdata == {2'h0, trigger_table_sel, 4'h0})
        else $error("feature read");
endmodule : uer_regs_properties

bind uer_regs uer_regs_properties #(.REVISION_CODE(REVISION_CODE), .DEVICE_ID_CODE(DEVICE_ID_CODE)) u_props (.*);

/* File: tb/uer_host.sv */
`timescale 1ns/1ps
// *****
// Host bus model, drives on falling edges
// *****
module uer_host (
    input  wire logic       clk_sys,
    output logic      [2:0] reg_addr,
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rvalid
);
    initial {reg_addr, reg_wr, reg_rd, reg_wdata} = 13'h0000;
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
        @(negedge clk_sys);
        // Released data is scrambled so stale values never look valid
        {reg_wdata, reg_wr} = {~d, 1'b0};
    endtask : wr
    task automatic rd(input logic [2:0] a, output logic [7:0] d, output logic ok);
        @(negedge clk_sys);
        {reg_addr, reg_rd} = {a, 1'b1};
        @(negedge clk_sys);
        {reg_rd, ok, d} = {1'b0, reg_rvalid, reg_rdata};
    endtask : rd
endmodule : uer_host

/* File: tb/uer_regs_tb.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("wrong value %s exp %h got %h", n, e, g); end end
module uer_regs_tb;
    localparam logic [7:0] REV = 8'h3c; // Arbitrary value
    localparam logic [7:0] DID = 8'h6d; // Arbitrary value
    logic clk_sys = 1'b0, reset_n = 1'b0, reg_wr, reg_rd, reg_rvalid, ok;
    logic [7:0] line_control_reg = 8'h00, divisor_low_byte = 8'h00, divisor_high_byte = 8'h00;
    logic [6:0] rx_fifo_count = 7'h00, tx_fifo_count = 7'h00, receive_trigger_value, transmit_trigger_value;
    logic [7:0] reg_wdata, reg_rdata, second_stop_char, d, rnd = 8'h1e;
    logic [2:0] reg_addr;
    logic [1:0] trigger_table_sel;
    int fails = 0, comparisons = 0;
    always #50 clk_sys = ~clk_sys;
    uer_host host (.*);
    uer_regs #(.REVISION_CODE(REV), .DEVICE_ID_CODE(DID)) dut (.*);
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    function automatic logic [7:0] cnt_exp(input logic t, input logic [6:0] r, input logic [6:0] x);
        return {t, t ? x : r};
    endfunction : cnt_exp
    task end_sim;
        if (fails == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_sim
    task rchk(input logic [2:0] a, input logic [7:0] e);
        host.rd(a, d, ok);
        `CHK("rvalid", 1'b1, ok)
        `CHK("rdata", e, d)
    endtask : rchk
    initial begin
        repeat (4) @(negedge clk_sys);
        reset_n = 1'b1;
        `CHK("stop", 8'h00, second_stop_char)
        line_control_reg = 8'hbf;
        rchk(3'h1, uer_pkg::FEATURE_CONTROL_RESET);
        for (int i = 0; i < 6; i++) begin
            rnd = lfsr(rnd);
            {rx_fifo_count, tx_fifo_count} = {rnd[6:0], ~rnd[6:0]};
            rchk(3'h0, cnt_exp(i[0], rx_fifo_count, tx_fifo_count));
            host.wr(3'h7, rnd);
            rchk(3'h7, rnd);
            host.wr(3'h1, {rnd[7:6], i[1:0], rnd[3:0]});
            `CHK("table", i[1:0], trigger_table_sel)
            rchk(3'h1, {2'h0, i[1:0], 4'h0});
            host.wr(3'h0, {1'b0, rnd[6:0]});
            `CHK("receive_trigger_value", rnd[6:0], receive_trigger_value)
            host.wr(3'h0, {1'b1, 7'h40 - i[6:0]});
            `CHK("transmit_trigger_value", 7'h40 - i[6:0], transmit_trigger_value)
        end
        host.wr(3'h0, 8'hff);
        `CHK("txclamp", 7'h40, transmit_trigger_value)
        rchk(3'h0, cnt_exp(1'b0, rx_fifo_count, tx_fifo_count));
        line_control_reg = 8'h80;
        host.wr(3'h7, ~rnd);
        host.wr(3'h0, 8'h85);
        host.wr(3'h1, ~DID);
        `CHK("stop", rnd, second_stop_char)
        `CHK("transmit_trigger_value", 7'h40, transmit_trigger_value)
        rchk(3'h0, REV);
        rchk(3'h1, DID);
        divisor_high_byte = 8'h01;
        rchk(3'h0, 8'h00);
        reset_n = 1'b0;
        repeat (2) @(negedge clk_sys);
        reset_n = 1'b1;
        line_control_reg = 8'hbf;
        `CHK("stop", 8'h00, second_stop_char)
        `CHK("table", 2'h2, trigger_table_sel)
        rchk(3'h0, cnt_exp(1'b0, rx_fifo_count, tx_fifo_count));
        end_sim();
    end
endmodule : uer_regs_tb
